// *** inc/wrc_pkg.sv ***
// Package of constants and types for the write checksum checker
package wrc_pkg;
   // Register byte offsets on the register bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] MODE_REG_FIVE_OFS = 8'h04;
   localparam logic [7:0] MULTIPURPOSE_REG_THREE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   // Control register field positions
   localparam int CTRL_CRC_EN_BIT = 0;
   localparam int CTRL_INV_EN_BIT = 1;
   localparam int CTRL_MASK_EN_BIT = 2;
   localparam int CTRL_WIDTH_LSB = 3;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // Sticky error bit in mode register five (address bit A4)
   localparam int MR5_ERR_BIT = 4;
   // Error status bit of multipurpose register three, page one
   localparam int MULTIPURPOSE_REG_THREE_ERR_BIT = 0;
   // Device organisation codes held in the control register
   localparam logic [1:0] WIDTH_X4 = 2'h0;
   localparam logic [1:0] WIDTH_X8 = 2'h1;
   localparam logic [1:0] WIDTH_X16 = 2'h2;
   // Frame layout: data in transfers 0-7, checksum from transfer 8
   localparam logic [3:0] XFER_DATA_LAST = 4'h7;
   localparam logic [3:0] XFER_CRC = 4'h8;
   localparam logic [3:0] XFER_LAST = 4'h9;
   localparam int CHOP_FIRST_FILL = 4;
   // Code word geometry
   localparam int CW_BITS = 72;
   localparam int FLAG_BASE = 64;
   localparam int X4_USED_BITS = 32;
   // Checksum generator x^8 + x^2 + x + 1, all-zero start
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // Error pulse width in command clocks (6 to 10 allowed)
   localparam logic [3:0] ALERT_PW_CYC = 4'h6;
   // Error flag latency limit in ns, and in whole cycles of 25 ns
   localparam int CLK_PERIOD_PS = 25000;
   localparam int ERR_LAT_NS = 13;
   localparam int ERR_LAT_CYC_RAW = ERR_LAT_NS * 1000 / CLK_PERIOD_PS;
   localparam int ERR_LAT_CYC = (ERR_LAT_CYC_RAW < 1) ? 1 : ERR_LAT_CYC_RAW;
   // AHB transfer type code for a non-sequential transfer
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // Frame receiver states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01,
      ST_CHECK = 2'b10
   } wrc_state_t;
endpackage

// *** inc/wrc_tree_if.sv ***
// Interface carrying one code word to a checksum tree and its result
`timescale 1ns/1ps
interface wrc_tree_if;
   logic [71:0] code; // Tree inputs after fill with ones
   logic [7:0] sum; // Computed checksum
   modport feed (output code, input sum);
   modport tree (input code, output sum);
endinterface

// *** verilog/wrc_tree.sv ***
// Combinational checksum tree over one 72-bit code word
`timescale 1ns/1ps
module wrc_tree (
   wrc_tree_if.tree t
);
   // Serial division unrolled; bit 71 enters first, start from zero
   always_comb begin
      logic [7:0] c;
      logic fb;
      c = wrc_pkg::CRC_INIT;
      fb = 1'b0;
      for (int i = wrc_pkg::CW_BITS - 1; i >= 0; i--) begin
         fb = c[7] ^ t.code[i];
         c = {c[6:0], 1'b0} ^ (fb ? wrc_pkg::CRC_POLY : 8'h00);
      end
      t.sum = c;
   end
endmodule

// *** verilog/wrc_top.sv ***
// Write checksum checker with error pulse, sticky bits and register port
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module wrc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_clk,
   input wire logic write_frame,
   input wire logic chopped_four_beat_burst,
   input wire logic [15:0] dq,
   input wire logic lower_inversion_flag_lane,
   input wire logic upper_inversion_flag_lane,
   output logic error_flag_n,
   output logic array_write,
   output logic [127:0] array_data,
   output logic [15:0] array_mask
);
   // Bundle of link pins passed through the two-flop synchroniser
   localparam int SW = 21;
   logic [SW-1:0] pins;
   logic [SW-1:0] sync1_q; // First stage, read only by the second
   logic [SW-1:0] sync2_q; // Stable copy used by the logic
   logic link_prev_q; // Previous synchronised link clock level
   logic link_rise; // One-cycle strobe per link clock rising edge
   logic frame_s; // Synchronised frame marker
   logic chop_s;
   logic [15:0] dq_s;
   logic flag_lo_s;
   logic flag_hi_s;
   // Frame receiver state
   wrc_pkg::wrc_state_t state_q;
   logic [3:0] xfer_q; // Transfer index within the frame
   logic chop_q; // Burst kind taken at the first transfer
   logic [71:0] cw_lo_q; // Lower code word as received
   logic [71:0] cw_hi_q; // Upper code word as received
   logic [15:0] crc_rx_q; // Received checksum bits
   // Tree feed and results
   wrc_tree_if lo_if ();
   wrc_tree_if hi_if ();
   logic [71:0] code_lo;
   logic [71:0] code_hi;
   logic err_lo;
   logic err_hi;
   logic err; // Checksum mismatch on the finished frame
   logic last_xfer; // Transfer that closes the frame
   // Registers
   logic [4:0] ctrl_q; // Checksum, inversion, mask enables and width
   logic mr5_err_q; // Sticky clear-type error bit
   logic multipurpose_reg_three_err_q; // Error status bit
   logic [15:0] frame_cnt_q; // Frames checked
   logic [15:0] err_cnt_q; // Mismatches seen
   logic [3:0] pw_cnt_q; // Remaining cycles of the error pulse
   // Bus data-phase bookkeeping
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic addr_ok;
   logic crc_en;
   logic inv_en;
   logic mask_en;
   logic [1:0] width;

   assign crc_en = ctrl_q[wrc_pkg::CTRL_CRC_EN_BIT];
   assign inv_en = ctrl_q[wrc_pkg::CTRL_INV_EN_BIT];
   assign mask_en = ctrl_q[wrc_pkg::CTRL_MASK_EN_BIT];
   assign width = ctrl_q[wrc_pkg::CTRL_WIDTH_LSB +: 2];

   assign pins = {upper_inversion_flag_lane, lower_inversion_flag_lane, dq,
                  chopped_four_beat_burst, write_frame, link_clk};
   assign frame_s = sync2_q[1];
   assign chop_s = sync2_q[2];
   assign dq_s = sync2_q[18:3];
   assign flag_lo_s = sync2_q[19];
   assign flag_hi_s = sync2_q[20];
   assign link_rise = sync2_q[0] & ~link_prev_q;

   // Two flops on every link pin; the link clock is only sampled here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         link_prev_q <= 1'b0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         link_prev_q <= sync2_q[0];
      end
   end

   // Without checksum a frame is eight transfers, with it ten
   assign last_xfer = crc_en ? (xfer_q == wrc_pkg::XFER_LAST) :
                      (xfer_q == wrc_pkg::XFER_DATA_LAST);

   // Frame receiver: one transfer per link clock rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= wrc_pkg::ST_IDLE;
         xfer_q <= 4'h0;
         chop_q <= 1'b0;
      end else begin
         case (state_q)
            wrc_pkg::ST_IDLE: begin
               // First transfer starts the frame
               if (link_rise && frame_s) begin
                  chop_q <= chop_s;
                  xfer_q <= 4'h1;
                  state_q <= wrc_pkg::ST_RECV;
               end
            end
            wrc_pkg::ST_RECV: begin
               // A frame that drops early is abandoned unchecked
               if (!frame_s) begin
                  state_q <= wrc_pkg::ST_IDLE;
                  // Restart the index so the next frame lands at transfer 0
                  xfer_q <= 4'h0;
               end else if (link_rise) begin
                  if (last_xfer) begin
                     state_q <= wrc_pkg::ST_CHECK;
                  end else begin
                     xfer_q <= xfer_q + 4'h1;
                  end
               end
            end
            wrc_pkg::ST_CHECK: begin
               // One cycle to compare and commit
               state_q <= wrc_pkg::ST_IDLE;
               xfer_q <= 4'h0;
            end
            default: begin
               state_q <= wrc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Lane i, transfer k lands in code bit 8i+k; checksum after data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cw_lo_q <= '1;
         cw_hi_q <= '1;
         crc_rx_q <= '0;
      end else if (link_rise && frame_s && state_q != wrc_pkg::ST_CHECK) begin
         if (xfer_q <= wrc_pkg::XFER_DATA_LAST) begin
            for (int i = 0; i < 8; i++) begin
               cw_lo_q[8*i + int'(xfer_q)] <= dq_s[i];
               cw_hi_q[8*i + int'(xfer_q)] <= dq_s[8+i];
            end
            cw_lo_q[wrc_pkg::FLAG_BASE + int'(xfer_q)] <= flag_lo_s;
            cw_hi_q[wrc_pkg::FLAG_BASE + int'(xfer_q)] <= flag_hi_s;
         end else if (xfer_q == wrc_pkg::XFER_CRC) begin
            // x4 carries checksum bits 0-3 here, wider parts all bits
            if (width == wrc_pkg::WIDTH_X4) begin
               crc_rx_q[3:0] <= dq_s[3:0];
            end else begin
               crc_rx_q <= dq_s;
            end
         end else if (width == wrc_pkg::WIDTH_X4) begin
            crc_rx_q[7:4] <= dq_s[3:0];
         end
      end
   end

   // Tree inputs: received bits, inversion not undone, unused set to one
   always_comb begin
      logic flag_used;
      flag_used = chop_q ? (inv_en | mask_en) : inv_en;
      code_lo = cw_lo_q;
      code_hi = cw_hi_q;
      if (!flag_used) begin
         code_lo[71:64] = 8'hff;
         code_hi[71:64] = 8'hff;
      end
      if (chop_q) begin
         // Transfers 4-7 count as ones in a chopped frame
         for (int i = 0; i < 9; i++) begin
            code_lo[8*i + wrc_pkg::CHOP_FIRST_FILL +: 4] = 4'hf;
            code_hi[8*i + wrc_pkg::CHOP_FIRST_FILL +: 4] = 4'hf;
         end
      end
      if (width == wrc_pkg::WIDTH_X4) begin
         code_lo[71:wrc_pkg::X4_USED_BITS] = '1;
      end
   end

   assign lo_if.code = code_lo;
   assign hi_if.code = code_hi;

   // Two identical trees, one per eight-bit half
   wrc_tree u_tree_lo (
      .t(lo_if.tree)
   );
   wrc_tree u_tree_hi (
      .t(hi_if.tree)
   );

   assign err_lo = lo_if.sum != crc_rx_q[7:0];
   assign err_hi = (width == wrc_pkg::WIDTH_X16) &&
                   (hi_if.sum != crc_rx_q[15:8]);
   assign err = crc_en && state_q == wrc_pkg::ST_CHECK &&
                (err_lo || err_hi);

   // Error pulse: low for a fixed count, then released; restarts on new error
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pw_cnt_q <= 4'h0;
         error_flag_n <= 1'b1;
      end else if (err) begin
         // Driven at the detecting edge, three to four cycles after the last link rise, past the 13 ns limit
         pw_cnt_q <= wrc_pkg::ALERT_PW_CYC - 4'h1;
         error_flag_n <= 1'b0;
      end else if (pw_cnt_q != 4'h0) begin
         pw_cnt_q <= pw_cnt_q - 4'h1;
      end else begin
         error_flag_n <= 1'b1;
      end
   end

   // Array commit after the check; masking with checksum blocks bad data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         array_write <= 1'b0;
         array_data <= '0;
         array_mask <= '0;
      end else begin
         array_write <= 1'b0;
         if (state_q == wrc_pkg::ST_CHECK) begin
            // Full writes commit even on error; the host retries
            array_write <= !(mask_en && err);
            for (int k = 0; k < 8; k++) begin
               for (int i = 0; i < 8; i++) begin
                  // Inversion undone only on the way into the array
                  array_data[8*i+k] <= cw_lo_q[8*i+k] ^
                     (inv_en & ~cw_lo_q[wrc_pkg::FLAG_BASE + k]);
                  array_data[64+8*i+k] <= cw_hi_q[8*i+k] ^
                     (inv_en & ~cw_hi_q[wrc_pkg::FLAG_BASE + k]);
               end
               array_mask[k] <= (mask_en & ~inv_en &
                  ~cw_lo_q[wrc_pkg::FLAG_BASE + k]) |
                  (chop_q && k >= wrc_pkg::CHOP_FIRST_FILL);
               array_mask[8+k] <= (mask_en & ~inv_en &
                  ~cw_hi_q[wrc_pkg::FLAG_BASE + k]) |
                  (chop_q && k >= wrc_pkg::CHOP_FIRST_FILL);
            end
         end
      end
   end

   // Bus address phase accepted this cycle
   assign addr_ok = hsel && hready && htrans == wrc_pkg::HTRANS_NONSEQ;

   // Register bus: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // Read data is latched at the address phase for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            wrc_pkg::CTRL_OFS: hrdata <= {27'h0000000, ctrl_q};
            wrc_pkg::MODE_REG_FIVE_OFS: begin
               hrdata <= 32'(mr5_err_q) << wrc_pkg::MR5_ERR_BIT;
            end
            wrc_pkg::MULTIPURPOSE_REG_THREE_OFS: begin
               hrdata <= 32'(multipurpose_reg_three_err_q) << wrc_pkg::MULTIPURPOSE_REG_THREE_ERR_BIT;
            end
            wrc_pkg::STATUS_OFS: hrdata <= {err_cnt_q, frame_cnt_q};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Control register written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= wrc_pkg::CTRL_RESET;
      end else if (wr_pend_q && wr_addr_q == wrc_pkg::CTRL_OFS) begin
         ctrl_q <= hwdata[4:0];
      end
   end

   // Sticky error bits: set by a mismatch, cleared only by a host write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mr5_err_q <= 1'b0;
         multipurpose_reg_three_err_q <= 1'b0;
      end else if (err) begin
         // Set wins over a clear in the same cycle
         mr5_err_q <= 1'b1;
         multipurpose_reg_three_err_q <= 1'b1;
      end else if (wr_pend_q) begin
         if (wr_addr_q == wrc_pkg::MODE_REG_FIVE_OFS &&
             !hwdata[wrc_pkg::MR5_ERR_BIT]) begin
            mr5_err_q <= 1'b0;
         end
         if (wr_addr_q == wrc_pkg::MULTIPURPOSE_REG_THREE_OFS &&
             !hwdata[wrc_pkg::MULTIPURPOSE_REG_THREE_ERR_BIT]) begin
            multipurpose_reg_three_err_q <= 1'b0;
         end
      end
   end

   // Frame and error counters, wrapping, for software visibility
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt_q <= 16'h0000;
         err_cnt_q <= 16'h0000;
      end else if (state_q == wrc_pkg::ST_CHECK) begin
         frame_cnt_q <= frame_cnt_q + 16'h0001;
         if (err) begin
            err_cnt_q <= err_cnt_q + 16'h0001;
         end
      end
   end
endmodule

// *** verification/wrc_chk.sv ***
// Checker of the write checksum block, bound to its top module
`timescale 1ns/1ps
module wrc_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic link_clk,
   input wire logic error_flag_n,
   input wire logic array_write
);
   logic lk_q; // Link clock level last cycle
   logic [7:0] since_q; // Cycles since the last link clock rise
   logic ap_v_q; // Bus address phase taken last edge
   logic ap_wr_q; // Its direction
   logic [7:0] ap_a_q; // Its offset
   logic [4:0] ctrl_q; // Shadow of the control register
   logic sticky_q; // Shadow of the sticky error bit
   logic stat_q; // Shadow of the error status bit
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Age of the last link edge; saturates so it never wraps to small
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lk_q <= 1'b0;
         since_q <= 8'hff;
      end else begin
         lk_q <= link_clk;
         if (link_clk && !lk_q)
            since_q <= 8'h00;
         else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
      end
   end
   // Bus address phase, kept for the data phase that follows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v_q <= 1'b0;
         ap_wr_q <= 1'b0;
         ap_a_q <= 8'h00;
      end else begin
         ap_v_q <= hsel && hready && htrans == wrc_pkg::HTRANS_NONSEQ;
         ap_wr_q <= hwrite;
         ap_a_q <= haddr[7:0];
      end
   end
   // Register shadows; a set wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= 5'h00;
         sticky_q <= 1'b0;
         stat_q <= 1'b0;
      end else begin
         if (ap_v_q && ap_wr_q && ap_a_q == wrc_pkg::CTRL_OFS)
            ctrl_q <= hwdata[4:0];
         if ($fell(error_flag_n))
            sticky_q <= 1'b1;
         else if (ap_v_q && ap_wr_q && !hwdata[4]
               && ap_a_q == wrc_pkg::MODE_REG_FIVE_OFS)
            sticky_q <= 1'b0;
         if ($fell(error_flag_n))
            stat_q <= 1'b1;
         else if (ap_v_q && ap_wr_q && !hwdata[0]
               && ap_a_q == wrc_pkg::MULTIPURPOSE_REG_THREE_OFS)
            stat_q <= 1'b0;
      end
   end
   sequence s_pulse;
      !error_flag_n [*6] ##1 error_flag_n;
   endsequence
   sequence s_commit;
      array_write ##1 !array_write;
   endsequence
   property p_pulse;
      $fell(error_flag_n) |-> s_pulse;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("error pulse not six cycles");
   property p_lat;
      $fell(error_flag_n) && !ctrl_q[2] |-> array_write;
   endproperty
   a_lat: assert property (p_lat)
      else $error("error pulse not at the check edge");
   property p_block;
      $fell(error_flag_n) && ctrl_q[2] |-> !array_write;
   endproperty
   a_block: assert property (p_block)
      else $error("masked write committed despite mismatch");
   property p_off;
      !ctrl_q[0] |-> error_flag_n;
   endproperty
   a_off: assert property (p_off)
      else $error("error reported with checksum off");
   property p_near;
      $fell(error_flag_n) |-> since_q <= 8'h08;
   endproperty
   a_near: assert property (p_near)
      else $error("error without a recent frame");
   property p_commit;
      $rose(array_write) |-> since_q <= 8'h08 ##0 s_commit;
   endproperty
   a_commit: assert property (p_commit)
      else $error("commit not one cycle after a frame");
   property p_sticky;
      ap_v_q && !ap_wr_q && ap_a_q == wrc_pkg::MODE_REG_FIVE_OFS
         |-> hrdata[4] == sticky_q;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("sticky error bit wrong");
   property p_stat;
      ap_v_q && !ap_wr_q && ap_a_q == wrc_pkg::MULTIPURPOSE_REG_THREE_OFS
         |-> hrdata[0] == stat_q;
   endproperty
   a_stat: assert property (p_stat)
      else $error("error status bit wrong");
endmodule
bind wrc_top wrc_chk wrc_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .link_clk, .error_flag_n,
   .array_write);

// *** verification/wrc_ctrl_model.sv ***
// Behavioural memory controller sending checksummed write frames
`timescale 1ns/1ps
module wrc_ctrl_model (
   output logic link_clk,
   output logic write_frame,
   output logic chopped_four_beat_burst,
   output logic [15:0] dq,
   output logic lower_inversion_flag_lane,
   output logic upper_inversion_flag_lane
);
   // Idle bus: link clock stands still outside frames
   initial begin
      link_clk = 1'b0;
      write_frame = 1'b0;
      chopped_four_beat_burst = 1'b0;
      dq = 16'h0000;
      lower_inversion_flag_lane = 1'b1;
      upper_inversion_flag_lane = 1'b1;
   end
   // Serial checksum, bit 71 first, from an all-zero start
   function automatic logic [7:0] crc8(input logic [71:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   // One frame of n transfers; flip corrupts chosen checksum bits
   task automatic send(input logic [4:0] cfg, input logic ch,
         input logic [127:0] dat, input logic [15:0] flg,
         input logic [15:0] flip, input int n);
      logic [71:0] cw [2];
      logic [15:0] sum;
      int nl;
      nl = (cfg[4:3] == wrc_pkg::WIDTH_X4) ? 4 :
         (cfg[4:3] == wrc_pkg::WIDTH_X8) ? 8 : 16;
      for (int h = 0; h < 2; h++) begin
         cw[h] = {72{1'b1}};
         for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 8; i++) begin
               if (8 * h + i < nl && !(ch && k >= 4))
                  cw[h][8 * i + k] = dat[64 * h + 8 * i + k];
            end
            if (nl > 8 * h + 4 && (cfg[1] || (ch && cfg[2]))
                  && !(ch && k >= 4))
               cw[h][64 + k] = flg[8 * h + k];
         end
         sum[8 * h +: 8] = crc8(cw[h]) ^ flip[8 * h +: 8];
      end
      // Start away from the command clock edge on which the bench returns
      #37;
      write_frame = 1'b1;
      chopped_four_beat_burst = ch;
      for (int t = 0; t < n; t++) begin
         // Unused lanes toggle so the design cannot lean on them
         for (int i = 0; i < 16; i++) begin
            if (i >= nl)
               dq[i] = t[0];
            else if (t < 8)
               dq[i] = cw[i / 8][8 * (i % 8) + t];
            else if (nl > 4)
               dq[i] = (t == 8) ? sum[i] : 1'b1;
            else
               dq[i] = sum[i + 4 * (t - 8)];
         end
         lower_inversion_flag_lane = (t < 8) ? cw[0][64 + t] : 1'b1;
         upper_inversion_flag_lane = (t < 8) ? cw[1][64 + t] : 1'b1;
         #100;
         link_clk = 1'b1;
         #100;
         link_clk = 1'b0;
      end
      write_frame = 1'b0;
      dq = ~dq;
      #400;
   endtask
endmodule

// *** verification/tb_write_crc_check_and_alert.sv ***
// Self-checking bench for the write checksum checker
`timescale 1ns/1ps
module tb_write_crc_check_and_alert;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic link_clk, write_frame, chopped_four_beat_burst, aw, ef;
   logic lower_inversion_flag_lane, upper_inversion_flag_lane;
   logic error_flag_n, array_write;
   logic [15:0] dq, array_mask;
   logic [127:0] array_data;
   int n_errors = 0;
   int tests_run = 0;
   localparam logic [127:0] DAT = {4{32'h3c96_a51e}}; // Frame payload
   localparam logic [15:0] FLG = 16'h5aa5; // Flag lanes, low = inverted
   // Width, chop/inv/mask, checksum flips, then error and commit expected
   localparam logic [22:0] ROWS [11] = '{
      {2'h0, 3'h0, 16'h0000, 2'h1}, {2'h0, 3'h0, 16'h0080, 2'h3},
      {2'h1, 3'h2, 16'h0000, 2'h1}, {2'h1, 3'h0, 16'h0001, 2'h3},
      {2'h2, 3'h2, 16'h0000, 2'h1}, {2'h2, 3'h2, 16'h0100, 2'h3},
      {2'h0, 3'h4, 16'h0000, 2'h1}, {2'h1, 3'h5, 16'h0000, 2'h1},
      {2'h1, 3'h5, 16'h0002, 2'h2}, {2'h2, 3'h6, 16'h0800, 2'h3},
      {2'h2, 3'h4, 16'h0000, 2'h1}};
   assign hready = hreadyout;
   wrc_top wrc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .link_clk,
      .write_frame, .chopped_four_beat_burst, .dq,
      .lower_inversion_flag_lane, .upper_inversion_flag_lane,
      .error_flag_n, .array_write, .array_data, .array_mask);
   wrc_ctrl_model wrc_ctrl_model_i (.link_clk, .write_frame,
      .chopped_four_beat_burst, .dq, .lower_inversion_flag_lane,
      .upper_inversion_flag_lane);
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic end_sim;
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic got, input logic exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic cmpw(input logic [127:0] got, input logic [127:0] exp,
         input string m);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // One single AHB transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= wrc_pkg::HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp(hresp, 1'b0, "bus response");
   endtask
   // Waits a bounded time for a commit or an error pulse
   task automatic wait_res;
      aw = 1'b0;
      ef = 1'b1;
      for (int n = 0; n < 300 && aw !== 1'b1 && ef !== 1'b0; n++) begin
         @(posedge hclk);
         #1;
         aw = array_write;
         ef = error_flag_n;
      end
   endtask
   task automatic frame(input logic [4:0] cfg, input logic ch,
         input logic [15:0] flip, input int n);
      ahb(1'b1, wrc_pkg::CTRL_OFS, {27'h0, cfg});
      fork
         wrc_ctrl_model_i.send(cfg, ch, DAT, FLG, flip, n);
         wait_res;
      join
      // Realign so the next bus request starts just after an edge
      @(posedge hclk);
   endtask
   // Stored data has inversion undone per eight-lane half and transfer
   function automatic logic [127:0] exp_data(input logic inv);
      logic [127:0] e;
      for (int b = 0; b < 128; b++)
         e[b] = DAT[b] ^ (inv & ~FLG[8 * (b / 64) + b % 8]);
      return e;
   endfunction
   initial begin
      #300000;
      n_errors++;
      end_sim;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cmp(error_flag_n, 1'b1, "error line after reset");
      cmp(array_write, 1'b0, "commit after reset");
      ahb(1'b0, 8'h10, 32'h0);
      cmpw({96'h0, rd}, 128'h0, "unmapped read");
      for (int r = 0; r < 11; r++) begin
         frame({ROWS[r][22:21], ROWS[r][18], ROWS[r][19], 1'b1},
            ROWS[r][20], ROWS[r][17:2], 10);
         cmp(ef, ~ROWS[r][1], "error line");
         cmp(aw, ROWS[r][0], "commit");
         if (ROWS[r][22:21] == 2'h2 && !ROWS[r][20])
            cmpw(array_data, exp_data(ROWS[r][19]), "array data");
         if (r == 10)
            cmpw({112'h0, array_mask}, 128'hf0f0, "chop mask");
      end
      ahb(1'b0, wrc_pkg::STATUS_OFS, 32'h0);
      cmpw({96'h0, rd}, {96'h0, 32'h0005_000b}, "frame counts");
      ahb(1'b0, wrc_pkg::MULTIPURPOSE_REG_THREE_OFS, 32'h0);
      cmp(rd[0], 1'b1, "status bit");
      ahb(1'b1, wrc_pkg::MODE_REG_FIVE_OFS, 32'h10);
      ahb(1'b0, wrc_pkg::MODE_REG_FIVE_OFS, 32'h0);
      cmp(rd[4], 1'b1, "sticky kept");
      ahb(1'b1, wrc_pkg::MODE_REG_FIVE_OFS, 32'h0);
      ahb(1'b0, wrc_pkg::MODE_REG_FIVE_OFS, 32'h0);
      cmp(rd[4], 1'b0, "sticky cleared");
      // Checksum off: eight transfers, committed without a check
      frame(5'h08, 1'b0, 16'h0000, 8);
      cmp(ef, 1'b1, "no error when off");
      cmp(aw, 1'b1, "commit when off");
      // A frame cut short is thrown away without a check
      frame(5'h09, 1'b0, 16'h0000, 5);
      cmp(aw, 1'b0, "aborted commit");
      cmp(ef, 1'b1, "aborted error");
      // Retry in full after the cut frame; no stale transfer index
      frame(5'h09, 1'b0, 16'h0000, 10);
      cmp(aw, 1'b1, "retry commit");
      cmp(ef, 1'b1, "retry error");
      // Second reset mid-run returns the control register to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, wrc_pkg::CTRL_OFS, 32'h0);
      cmpw({96'h0, rd}, 128'h0, "control after reset");
      end_sim;
   end
endmodule
